/* verilog/linefeed_state_control.v */
`timescale 1ns/1ns
`default_nettype none
`include "linefeed_map.vh"

// Function
// - decode three-bit code into eight states
// - code 000 puts both leads high-impedance
// - reset state is open
// - power fault forces open automatically
// - 001 forward active, audio off until off-hook
// - active states idle in low power on-hook
// - 010 forward feed with on-hook audio
// - 011 tip open, ring fed
// - 100 drives ringing waveform
// - 101 reverse active, audio off until off-hook
// - 110 reverse feed with on-hook audio
// - open-circuit voltage 0..63 v, 1 v steps
// - current limit 18..45 ma, 0.87 ma steps
// - 111 ring open, tip fed
module linefeed_state_control
#(
   parameter VOLTAGE_W = `VOLTAGE_WIDTH,
   parameter LIMIT_W   = `LIMIT_WIDTH
)
(
   // clock and reset
   input  wire                 clk_in,
   input  wire                 rst_n_in,
   // host settings
   input  wire                 code_wr_in,
   input  wire [2:0]           linefeed_state_code_in,
   input  wire                 voltage_wr_in,
   input  wire [VOLTAGE_W-1:0] open_circuit_voltage_in,
   input  wire                 limit_wr_in,
   input  wire [LIMIT_W-1:0]   loop_current_limit_in,
   // line status from the high-voltage chip
   input  wire                 power_fault_in,
   input  wire                 off_hook_in,
   // status to host
   output reg  [2:0]           state_shadow_out,
   output reg                  fault_open_out,
   // drive to the high-voltage chip
   output reg  [1:0]           tip_mode_out,
   output reg  [1:0]           ring_mode_out,
   output reg                  reverse_out,
   output reg                  audio_on_out,
   output reg                  low_power_out,
   output reg  [VOLTAGE_W-1:0] open_circuit_voltage_out,
   output reg  [LIMIT_W-1:0]   loop_current_limit_out
);

   // ==========================================================
   // internal state
   reg  [2:0]           state_q;
   reg  [2:0]           state_d;
   reg                  fault_q;
   reg                  fault_d;
   reg  [VOLTAGE_W-1:0] voltage_q;
   reg  [LIMIT_W-1:0]   limit_q;
   reg                  audio_d;
   reg                  low_power_d;
   wire                 code_take;
   wire [1:0]           tip_mode;
   wire [1:0]           ring_mode;
   wire                 rev;
   wire                 oht;
   wire                 act;

   // ==========================================================
   // host write qualification
   // a fault in the same cycle wins over a code write
   assign code_take = code_wr_in & ~power_fault_in;

   // ==========================================================
   // next applied state
   always @*
   begin
      state_d = state_q;
      if (power_fault_in)
      begin
         state_d = `STATE_OPEN;
      end
      else if (code_take)
      begin
         state_d = linefeed_state_code_in;
      end
   end

   // ==========================================================
   // fault-open flag: set by a fault, cleared only by reset or a code write
   always @*
   begin
      fault_d = fault_q;
      if (power_fault_in)
      begin
         fault_d = 1'b1;
      end
      else if (code_take)
      begin
         fault_d = 1'b0;
      end
   end

   // ==========================================================
   // applied state and fault flag registers
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= `STATE_OPEN;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         fault_q <= 1'b0;
      end
      else
      begin
         fault_q <= fault_d;
      end
   end

   // ==========================================================
   // open-circuit voltage setting, one volt per code
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         voltage_q <= `VOLTAGE_RESET;
      end
      else if (voltage_wr_in)
      begin
         voltage_q <= open_circuit_voltage_in;
      end
   end

   // ==========================================================
   // loop current limit setting, every code is a legal step
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         limit_q <= `LIMIT_RESET;
      end
      else if (limit_wr_in)
      begin
         limit_q <= loop_current_limit_in;
      end
   end

   // ==========================================================
   // lead drive decode of the applied state
   linefeed_lead_decode u_decode
   (
      .state_in      (state_q),
      .tip_mode_out  (tip_mode),
      .ring_mode_out (ring_mode),
      .reverse_out   (rev),
      .oht_out       (oht),
      .active_out    (act)
   );

   // ==========================================================
   // audio path and standby power
   always @*
   begin
      audio_d     = 1'b0;
      low_power_d = 1'b0;
      if (oht)
      begin
         audio_d = 1'b1;
      end
      else if (act)
      begin
         audio_d     = off_hook_in;
         low_power_d = ~off_hook_in;
      end
   end

   // ==========================================================
   // registered drive to the line chip
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tip_mode_out <= `LEAD_HIZ;
      end
      else
      begin
         tip_mode_out <= tip_mode;
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ring_mode_out <= `LEAD_HIZ;
      end
      else
      begin
         ring_mode_out <= ring_mode;
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         reverse_out <= 1'b0;
      end
      else
      begin
         reverse_out <= rev;
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         audio_on_out <= 1'b0;
      end
      else
      begin
         audio_on_out <= audio_d;
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         low_power_out <= 1'b0;
      end
      else
      begin
         low_power_out <= low_power_d;
      end
   end

   // ==========================================================
   // registered settings to the line chip
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         open_circuit_voltage_out <= `VOLTAGE_RESET;
      end
      else
      begin
         open_circuit_voltage_out <= voltage_q;
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         loop_current_limit_out <= `LIMIT_RESET;
      end
      else
      begin
         loop_current_limit_out <= limit_q;
      end
   end

   // ==========================================================
   // status back to the host
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_shadow_out <= `STATE_OPEN;
      end
      else
      begin
         state_shadow_out <= state_q;
      end
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         fault_open_out <= 1'b0;
      end
      else
      begin
         fault_open_out <= fault_q;
      end
   end

endmodule // linefeed_state_control

`default_nettype wire

/* include/linefeed_map.vh */
`ifndef LINEFEED_MAP_VH
`define LINEFEED_MAP_VH

// ==========================================================
// linefeed state codes
`define STATE_OPEN        3'h0
`define STATE_FWD_ACTIVE  3'h1
`define STATE_FWD_OHT     3'h2
`define STATE_TIP_OPEN    3'h3
`define STATE_RINGING     3'h4
`define STATE_REV_ACTIVE  3'h5
`define STATE_REV_OHT     3'h6
`define STATE_RING_OPEN   3'h7

// ==========================================================
// settings: voltage in 1 v steps, 0..63; current 18 ma + n*0.87 ma
`define VOLTAGE_WIDTH     6
`define VOLTAGE_MAX       6'h3f
`define VOLTAGE_RESET     6'h00
`define LIMIT_WIDTH       5
`define LIMIT_MAX         5'h1f
`define LIMIT_RESET       5'h00

// ==========================================================
// lead drive modes toward the high-voltage chip
`define LEAD_HIZ       2'h0
`define LEAD_FEED      2'h1
`define LEAD_RING      2'h2

`endif

/* verilog/linefeed_lead_decode.v */
`timescale 1ns/1ns
`default_nettype none
`include "linefeed_map.vh"

// ==========================================================
// combinational decode of an applied state code into lead drive
module linefeed_lead_decode
(
   // state
   input  wire [2:0] state_in,
   // lead drive
   output reg  [1:0] tip_mode_out,
   output reg  [1:0] ring_mode_out,
   output reg        reverse_out,
   output reg        oht_out,
   output reg        active_out
);

   always @*
   begin
      tip_mode_out  = `LEAD_FEED;
      ring_mode_out = `LEAD_FEED;
      reverse_out   = 1'b0;
      oht_out       = 1'b0;
      active_out    = 1'b0;
      case (state_in)
         `STATE_OPEN:
         begin
            tip_mode_out  = `LEAD_HIZ;
            ring_mode_out = `LEAD_HIZ;
         end
         `STATE_FWD_ACTIVE: active_out = 1'b1;
         `STATE_FWD_OHT:    oht_out = 1'b1;
         `STATE_TIP_OPEN:   tip_mode_out = `LEAD_HIZ;
         `STATE_RINGING:
         begin
            tip_mode_out  = `LEAD_RING;
            ring_mode_out = `LEAD_RING;
         end
         `STATE_REV_ACTIVE:
         begin
            reverse_out = 1'b1;
            active_out  = 1'b1;
         end
         `STATE_REV_OHT:
         begin
            reverse_out = 1'b1;
            oht_out     = 1'b1;
         end
         default:        ring_mode_out = `LEAD_HIZ;
      endcase
   end

endmodule // linefeed_lead_decode

`default_nettype wire

/* verification/linefeed_state_control_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// port checks
module linefeed_state_control_monitor #(parameter VOLTAGE_W = 6, parameter LIMIT_W = 5)
(
   input wire logic clk_in, rst_n_in, code_wr_in, voltage_wr_in, limit_wr_in, power_fault_in,
   input wire logic off_hook_in, fault_open_out, audio_on_out, low_power_out,
   input wire logic [2:0] linefeed_state_code_in, state_shadow_out,
   input wire logic [1:0] tip_mode_out, ring_mode_out,
   input wire logic [VOLTAGE_W-1:0] open_circuit_voltage_in, open_circuit_voltage_out,
   input wire logic [LIMIT_W-1:0] loop_current_limit_in, loop_current_limit_out
);
   wire [2:0] s = state_shadow_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_open; s == 3'h0 |-> tip_mode_out == 2'h0 && ring_mode_out == 2'h0; endproperty
   a_open: assert property (p_open) else $error("lead not open");
   property p_gnd; s == 3'h3 || s == 3'h7 |->
      tip_mode_out == {1'b0, s[2]} && ring_mode_out == {1'b0, !s[2]}; endproperty
   a_gnd: assert property (p_gnd) else $error("ground start leads");
   property p_fault; power_fault_in |-> ##2 fault_open_out && s == 3'h0; endproperty
   a_fault: assert property (p_fault) else $error("fault not open");
   property p_hold; fault_open_out && !code_wr_in && !$past(code_wr_in) |=> fault_open_out;
   endproperty
   a_hold: assert property (p_hold) else $error("fault open left");
   property p_lp; low_power_out |-> !$past(off_hook_in) && (s == 3'h1 || s == 3'h5); endproperty
   a_lp: assert property (p_lp) else $error("low power wrong");
   property p_oht; s == 3'h2 || s == 3'h6 |-> audio_on_out; endproperty
   a_oht: assert property (p_oht) else $error("audio off");
   property p_code; code_wr_in && !power_fault_in ##1 !code_wr_in && !power_fault_in
      |=> s == $past(linefeed_state_code_in, 2); endproperty
   a_code: assert property (p_code) else $error("state not applied");
   property p_voltage; voltage_wr_in ##1 !voltage_wr_in
      |=> open_circuit_voltage_out == $past(open_circuit_voltage_in, 2); endproperty
   a_voltage: assert property (p_voltage) else $error("voltage not loaded");
   property p_limit; limit_wr_in ##1 !limit_wr_in
      |=> loop_current_limit_out == $past(loop_current_limit_in, 2); endproperty
   a_limit: assert property (p_limit) else $error("limit not loaded");
endmodule // linefeed_state_control_monitor
bind linefeed_state_control linefeed_state_control_monitor
   #(.VOLTAGE_W(VOLTAGE_W), .LIMIT_W(LIMIT_W)) i_mon (.*);
`default_nettype wire

/* verification/linefeed_line_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// high-voltage line chip
module linefeed_line_model
(
   input  wire logic [1:0] tip_mode_in, ring_mode_in,
   input  wire logic       fault_cmd_in, hook_cmd_in,
   output logic            power_fault_out, off_hook_out
);
   // loop current, hence hook detect, needs a fed lead
   assign off_hook_out = hook_cmd_in && (tip_mode_in == 2'h1 || ring_mode_in == 2'h1);
   assign power_fault_out = fault_cmd_in;
endmodule // linefeed_line_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// bench
module testbench;
   logic clk_in = 0, rst_n_in = 0, code_wr_in = 0, voltage_wr_in = 0, limit_wr_in = 0;
   logic fault_cmd = 0, hook_cmd = 0, power_fault_in, off_hook_in, fault_open_out;
   logic reverse_out, audio_on_out, low_power_out;
   logic [2:0] linefeed_state_code_in = 0, state_shadow_out;
   logic [1:0] tip_mode_out, ring_mode_out;
   logic [5:0] open_circuit_voltage_in = 0, open_circuit_voltage_out;
   logic [4:0] loop_current_limit_in = 0, loop_current_limit_out;
   int fail_count = 0, checks_done = 0;
   wire [15:0] obs = {5'h0, fault_open_out, state_shadow_out, tip_mode_out, ring_mode_out,
                      reverse_out, audio_on_out, low_power_out};
   initial forever #4 clk_in = ~clk_in;
   linefeed_state_control i_linefeed_state_control (.*);
   linefeed_line_model i_linefeed_line_model (.tip_mode_in(tip_mode_out),
      .ring_mode_in(ring_mode_out), .fault_cmd_in(fault_cmd), .hook_cmd_in(hook_cmd),
      .power_fault_out(power_fault_in), .off_hook_out(off_hook_in));
   task chk(input logic [15:0] g, e);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task test_done;
      $display("checks %0d failures %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [15:0] ex(input logic [2:0] s, input logic h);
      return {6'h0, s, (s == 0 || s == 3) ? 2'h0 : (s == 4) ? 2'h2 : 2'h1,
         (s == 0 || s == 7) ? 2'h0 : (s == 4) ? 2'h2 : 2'h1, s == 5 || s == 6,
         s == 2 || s == 6 || ((s == 1 || s == 5) && h), (s == 1 || s == 5) && !h};
   endfunction
   task wr(input logic [2:0] c);
      @(negedge clk_in) {code_wr_in, linefeed_state_code_in} = {1'b1, c};
      @(negedge clk_in) code_wr_in = 0;
      @(negedge clk_in);
   endtask
   task t_codes;
      for (int i = 7; i >= 0; i--)
      begin
         wr(i[2:0]);
         chk(obs, ex(i[2:0], 0));
      end
   endtask
   task t_hook(input logic [2:0] s);
      wr(s);
      @(negedge clk_in) hook_cmd = 1;
      @(negedge clk_in) chk(obs, ex(s, 1));
      hook_cmd = 0;
      @(negedge clk_in) chk(obs, ex(s, 0));
   endtask
   task t_fault;
      wr(4);
      @(negedge clk_in) {fault_cmd, code_wr_in, linefeed_state_code_in} = 5'h1a;
      @(negedge clk_in) {fault_cmd, code_wr_in} = 2'h0;
      repeat (3) @(negedge clk_in);
      chk(obs, ex(0, 0) | 16'h0400);
      wr(6);
      chk(obs, ex(6, 0));
   endtask
   task t_set(input logic [5:0] v, input logic [4:0] c);
      @(negedge clk_in) {voltage_wr_in, open_circuit_voltage_in} = {1'b1, v};
      {limit_wr_in, loop_current_limit_in} = {1'b1, c};
      @(negedge clk_in) {voltage_wr_in, limit_wr_in} = 2'h0;
      @(negedge clk_in) chk(open_circuit_voltage_out, v);
      chk(loop_current_limit_out, c);
   endtask
   initial
   begin
      repeat (12) @(posedge clk_in);
      @(negedge clk_in) rst_n_in = 1;
      chk(obs, ex(0, 0));
      t_codes;
      t_hook(3'h1);
      t_hook(3'h5);
      t_fault;
      t_set(6'h3f, 5'h00);
      t_set(6'h00, 5'h1f);
      @(negedge clk_in) rst_n_in = 0;
      @(negedge clk_in) chk(obs, ex(0, 0));
      chk(loop_current_limit_out, 5'h00);
      rst_n_in = 1;
      test_done;
   end
   initial
   begin
      #20000;
      fail_count++;
      test_done;
   end
endmodule // testbench
`default_nettype wire
